// ### src/sfc_pkg.sv
// Constants and types for the serial flash command sequencer.
// Assumes a single 100 MHz core clock and a single-lane mode-0 flash.
//
// Overview of operation
// - Fast read: 0x0B, address, dummy, data stream.
// - Write status: 0x01 plus exactly one byte.
// - Page program: 0x02, address, data bytes.
// - Sector erase: 0x20 plus address only.
// - Never drive flash hold or write-protect.
// - Reset pin low tri-states clock, data, select.
// - Second chip select unaffected by reset pin.
// - Program flash on command once firmware valid.
// - Control port paced by slowest party.
// - Single lane, mode 0 for every command.
// - Boot: enable, poll latch, clear status.
// - Enable and poll latch before program/erase.
// - Status bit0 busy, bit1 enable latch.
package sfc_pkg;

  // ----------------------------------------------------------------
  // Opcodes and status fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam int STATUS_WRITE_IN_PROGRESS_BIT = 0;
  localparam int STATUS_WRITE_ENABLE_LATCH_BIT = 1;
  localparam logic [7:0] STATUS_BOOT_VALUE = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CS_HIGH_NS = 200;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 2;

  // Commands accepted on the control port.
  typedef enum logic [2:0] {
    CMD_FAST_READ,
    CMD_READ_STATUS,
    CMD_WRITE_STATUS,
    CMD_WRITE_ENABLE,
    CMD_PAGE_PROGRAM,
    CMD_SECTOR_ERASE,
    CMD_CHIP_ERASE
  } sfc_cmd_t;

endpackage

// ### src/sfc_seq.sv
// Serial flash command sequencer: command port in, mode-0 flash pins out.
// Assumes the command port and firmware flag come from clk logic; the
// reset pin and the flash data-in pin are asynchronous and are synchronised.
`timescale 1ns/1ps
`default_nettype none
module sfc_seq
  import sfc_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_in_n,
  input wire logic fw_valid,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sfc_cmd_t cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic [7:0] cmd_status,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [7:0] status,
  output logic busy,
  output logic done,
  output logic flash_sclk,
  output logic flash_sclk_oe,
  output logic flash_mosi,
  output logic flash_mosi_oe,
  output logic flash_cs0_n,
  output logic flash_cs0_oe,
  output logic flash_cs1_n,
  input wire logic flash_miso
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_r, rst_s_r, miso_meta_r, miso_s_r;

  // Two stages each; only the second stage is read by the logic.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_s_r <= 1'b0;
      miso_meta_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      rst_meta_r <= reset_in_n;
      rst_s_r <= rst_meta_r;
      miso_meta_r <= flash_miso;
      miso_s_r <= miso_meta_r;
    end
  end

  function automatic logic needs_we(input sfc_cmd_t op);
    needs_we = (op == CMD_WRITE_STATUS) || (op == CMD_PAGE_PROGRAM) ||
               (op == CMD_SECTOR_ERASE) || (op == CMD_CHIP_ERASE);
  endfunction

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {X_IDLE, X_RUN, X_WAIT, X_GAP} sfc_xst_t;
  localparam int GAP_W = $clog2(CS_HIGH_CYC + 1);
  localparam int TK_W = $clog2(HALF_CYC + 1);

  sfc_xst_t x_r, x_nxt;
  logic sclk_r, sclk_nxt, cs_r, cs_nxt, mosi_r, mosi_nxt;
  logic [TK_W-1:0] tk_r, tk_nxt;
  logic [2:0] bit_r, bit_nxt, hleft_r, hleft_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, rdd_r, rdd_nxt;
  logic [39:0] hdr_r, hdr_nxt;
  logic [LEN_W-1:0] dleft_r, dleft_nxt;
  logic dwr_r, dwr_nxt, crd_r, crd_nxt, rdv_r, rdv_nxt;
  logic [GAP_W-1:0] gap_r, gap_nxt;
  logic x_start, x_done;
  logic [39:0] d_hdr;
  logic [2:0] d_n;
  logic [LEN_W-1:0] d_len;
  logic d_wr;

  assign x_done = (x_r == X_GAP) && (gap_r == '0);
  assign wr_ready = (x_r == X_WAIT) && rst_s_r;

  // Mode 0: clock idles low, data moves on the falling edge and is
  // sampled on the rising one; the synchronised data-in lags two cycles,
  // so it is taken at the falling tick, which still sees the bit.
  always_comb begin
    x_nxt = x_r;
    sclk_nxt = sclk_r;
    cs_nxt = cs_r;
    mosi_nxt = mosi_r;
    tk_nxt = tk_r;
    bit_nxt = bit_r;
    hleft_nxt = hleft_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rdd_nxt = rdd_r;
    hdr_nxt = hdr_r;
    dleft_nxt = dleft_r;
    dwr_nxt = dwr_r;
    crd_nxt = crd_r;
    rdv_nxt = 1'b0;
    gap_nxt = gap_r;
    case (x_r)
      X_IDLE: begin
        cs_nxt = 1'b1;
        if (x_start) begin
          x_nxt = X_RUN;
          cs_nxt = 1'b0;
          tx_nxt = d_hdr[39:32];
          mosi_nxt = d_hdr[39];
          hdr_nxt = {d_hdr[31:0], 8'h00};
          hleft_nxt = d_n - 3'd1;
          dleft_nxt = d_len;
          dwr_nxt = d_wr;
          crd_nxt = 1'b0;
          bit_nxt = 3'd0;
          tk_nxt = '0;
        end
      end
      X_RUN: begin
        if (tk_r == TK_W'(HALF_CYC - 1)) begin
          tk_nxt = '0;
          if (!sclk_r) begin
            sclk_nxt = 1'b1;
          end else begin
            sclk_nxt = 1'b0;
            rx_nxt = {rx_r[6:0], miso_s_r};
            if (bit_r != 3'd7) begin
              bit_nxt = bit_r + 3'd1;
              tx_nxt = {tx_r[6:0], 1'b0};
              mosi_nxt = tx_r[6];
            end else begin
              bit_nxt = 3'd0;
              if (crd_r) begin
                rdv_nxt = 1'b1;
                rdd_nxt = {rx_r[6:0], miso_s_r};
              end
              if (hleft_r != 3'd0) begin
                tx_nxt = hdr_r[39:32];
                mosi_nxt = hdr_r[39];
                hdr_nxt = {hdr_r[31:0], 8'h00};
                hleft_nxt = hleft_r - 3'd1;
              end else if (dleft_r != '0 && dwr_r) begin
                x_nxt = X_WAIT; // Program data streams until the count ends.
              end else if (dleft_r != '0) begin
                tx_nxt = DUMMY_BYTE;
                mosi_nxt = 1'b0;
                crd_nxt = 1'b1; // Read data keeps flowing under one select.
                dleft_nxt = dleft_r - LEN_W'(1);
              end else begin
                // Select rises a cycle after the last falling clock edge, never with it.
                x_nxt = X_GAP;
                gap_nxt = GAP_W'(CS_HIGH_CYC);
              end
            end
          end
        end else begin
          tk_nxt = tk_r + TK_W'(1);
        end
      end
      X_WAIT: begin
        // Clock holds low while the data source stalls; mode 0 allows it.
        if (wr_valid) begin
          x_nxt = X_RUN;
          tx_nxt = wr_data;
          mosi_nxt = wr_data[7];
          dleft_nxt = dleft_r - LEN_W'(1);
          tk_nxt = '0;
        end
      end
      X_GAP: begin
        cs_nxt = 1'b1;
        if (gap_r == '0) begin
          x_nxt = X_IDLE;
        end else begin
          gap_nxt = gap_r - GAP_W'(1);
        end
      end
      default: x_nxt = X_IDLE;
    endcase
    if (!rst_s_r) begin
      x_nxt = X_IDLE;
      sclk_nxt = 1'b0;
      // A cut frame drops the clock first; the select follows once it is low.
      cs_nxt = sclk_r ? cs_r : 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_r <= X_IDLE;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      mosi_r <= 1'b0;
      tk_r <= '0;
      bit_r <= 3'd0;
      hleft_r <= 3'd0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rdd_r <= 8'h00;
      hdr_r <= 40'h0;
      dleft_r <= '0;
      dwr_r <= 1'b0;
      crd_r <= 1'b0;
      rdv_r <= 1'b0;
      gap_r <= '0;
    end else begin
      x_r <= x_nxt;
      sclk_r <= sclk_nxt;
      cs_r <= cs_nxt;
      mosi_r <= mosi_nxt;
      tk_r <= tk_nxt;
      bit_r <= bit_nxt;
      hleft_r <= hleft_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rdd_r <= rdd_nxt;
      hdr_r <= hdr_nxt;
      dleft_r <= dleft_nxt;
      dwr_r <= dwr_nxt;
      crd_r <= crd_nxt;
      rdv_r <= rdv_nxt;
      gap_r <= gap_nxt;
    end
  end

  // Pins released while the reset pin is low; hold and write-protect
  // have no pin here at all, so they are never driven.
  assign flash_sclk = sclk_r;
  assign flash_mosi = mosi_r;
  assign flash_cs0_n = cs_r;
  assign flash_sclk_oe = rst_s_r;
  assign flash_mosi_oe = rst_s_r;
  assign flash_cs0_oe = rst_s_r;
  assign flash_cs1_n = 1'b1; // Second select is never used nor released.
  assign rd_valid = rdv_r;
  assign rd_data = rdd_r;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ENABLE, S_POLL_LATCH, S_OP, S_POLL_BUSY} sfc_sst_t;

  sfc_sst_t s_r, s_nxt;
  sfc_cmd_t op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [LEN_W-1:0] len_r, len_nxt;
  logic [7:0] wst_r, wst_nxt, stat_r, stat_nxt;
  logic boot_pend_r, boot_pend_nxt, iss_r, iss_nxt, done_r, done_nxt;

  // Commands are only taken once firmware is up; the ready handshake
  // lets the control-port side move at its own pace.
  assign cmd_ready = (s_r == S_IDLE) && !boot_pend_r && fw_valid && rst_s_r;
  assign x_start = (s_r != S_IDLE) && (x_r == X_IDLE) && !iss_r && rst_s_r;

  // Descriptor of the transfer the current step needs.
  always_comb begin
    d_hdr = {OP_READ_STATUS, 32'h0};
    d_n = 3'd1;
    d_len = LEN_W'(1);
    d_wr = 1'b0;
    case (s_r)
      S_ENABLE: begin
        d_hdr = {OP_WRITE_ENABLE, 32'h0}; // Opcode alone.
        d_len = '0;
      end
      S_OP: begin
        d_len = '0;
        case (op_r)
          CMD_FAST_READ: begin
            d_hdr = {OP_FAST_READ, addr_r, DUMMY_BYTE};
            d_n = 3'd5;
            d_len = len_r;
          end
          CMD_READ_STATUS: d_len = LEN_W'(1);
          CMD_WRITE_STATUS: begin
            d_hdr = {OP_WRITE_STATUS, wst_r, 24'h0}; // One byte only.
            d_n = 3'd2;
          end
          CMD_WRITE_ENABLE: d_hdr = {OP_WRITE_ENABLE, 32'h0};
          CMD_PAGE_PROGRAM: begin
            d_hdr = {OP_PAGE_PROGRAM, addr_r, 8'h00};
            d_n = 3'd4;
            d_len = len_r;
            d_wr = 1'b1;
          end
          CMD_SECTOR_ERASE: begin
            d_hdr = {OP_SECTOR_ERASE, addr_r, 8'h00};
            d_n = 3'd4;
          end
          CMD_CHIP_ERASE: d_hdr = {OP_CHIP_ERASE, 32'h0};
          default: d_hdr = {OP_READ_STATUS, 32'h0};
        endcase
      end
      default: d_hdr = {OP_READ_STATUS, 32'h0};
    endcase
  end

  // Write-type commands are wrapped in enable, latch poll and busy poll.
  always_comb begin
    s_nxt = s_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    wst_nxt = wst_r;
    stat_nxt = stat_r;
    boot_pend_nxt = boot_pend_r;
    iss_nxt = iss_r;
    done_nxt = 1'b0;
    if (x_start) begin
      iss_nxt = 1'b1;
    end
    case (s_r)
      S_IDLE: begin
        if (boot_pend_r && rst_s_r) begin
          op_nxt = CMD_WRITE_STATUS; // Boot clears all protection.
          wst_nxt = STATUS_BOOT_VALUE;
          boot_pend_nxt = 1'b0;
          s_nxt = S_ENABLE;
        end else if (cmd_valid && cmd_ready) begin
          op_nxt = cmd_op;
          addr_nxt = cmd_addr;
          len_nxt = cmd_len;
          wst_nxt = cmd_status;
          s_nxt = needs_we(cmd_op) ? S_ENABLE : S_OP;
        end
      end
      default: begin
        if (x_done) begin
          iss_nxt = 1'b0;
          if (s_r != S_ENABLE && !(s_r == S_OP && op_r != CMD_READ_STATUS)) begin
            stat_nxt = rd_data;
          end
          case (s_r)
            S_ENABLE: s_nxt = S_POLL_LATCH;
            S_POLL_LATCH: begin
              if (rd_data[STATUS_WRITE_ENABLE_LATCH_BIT]) begin
                s_nxt = S_OP;
              end
            end
            S_OP: begin
              if (needs_we(op_r)) begin
                s_nxt = S_POLL_BUSY;
              end else begin
                s_nxt = S_IDLE;
                done_nxt = 1'b1;
              end
            end
            default: begin
              if (!rd_data[STATUS_WRITE_IN_PROGRESS_BIT]) begin
                s_nxt = S_IDLE;
                done_nxt = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
    if (!rst_s_r) begin
      s_nxt = S_IDLE;
      iss_nxt = 1'b0;
      boot_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= S_IDLE;
      op_r <= CMD_FAST_READ;
      addr_r <= 24'h0;
      len_r <= '0;
      wst_r <= STATUS_RESET;
      stat_r <= STATUS_RESET;
      boot_pend_r <= 1'b1;
      iss_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      wst_r <= wst_nxt;
      stat_r <= stat_nxt;
      boot_pend_r <= boot_pend_nxt;
      iss_r <= iss_nxt;
      done_r <= done_nxt;
    end
  end

  assign status = stat_r;
  assign busy = (s_r != S_IDLE);
  assign done = done_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pins_released_a: assert property (@(posedge clk) disable iff (!arst_n)
    !rst_s_r |-> !flash_sclk_oe && !flash_mosi_oe && !flash_cs0_oe)
    else $error("flash pins driven while reset pin low");
  cs1_held_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(rst_s_r) |-> flash_cs1_n [*4])
    else $error("second select moved");
  mode0_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(flash_cs0_n) |-> !flash_sclk && !$past(flash_sclk))
    else $error("select moved with clock high");
  latch_before_op_a: assert property (@(posedge clk) disable iff (!arst_n)
    x_start && s_r == S_OP && needs_we(op_r) |-> stat_r[STATUS_WRITE_ENABLE_LATCH_BIT])
    else $error("write-type command without enable latch");
  status_one_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
    x_start && s_r == S_OP && op_r == CMD_WRITE_STATUS |-> d_n == 3'd2 && d_len == '0)
    else $error("status write not single byte");
  busy_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    done && needs_we(op_r) |-> !stat_r[STATUS_WRITE_IN_PROGRESS_BIT])
    else $error("done while flash still busy");
  cmd_gated_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid && cmd_ready |=> busy && !done)
    else $error("command not started");
  boot_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(boot_pend_r) && rst_s_r |-> s_r == S_ENABLE && wst_r == STATUS_BOOT_VALUE)
    else $error("boot sequence wrong");
  first_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
    x_start && s_r == S_OP && op_r == CMD_FAST_READ |=> tx_r == OP_FAST_READ ##0 hleft_r == 3'd4)
    else $error("fast read header wrong");

endmodule
`default_nettype wire

// ### bench/sfc_flash_model.sv
// Behavioural single-lane mode-0 serial flash, the sequencer's far side.
// Assumes the bench resolves released pins to their pull levels first.
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_model #(
  parameter int LATCH_POLLS = 2,
  parameter int BUSY_POLLS = 3
) (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  // ----------------------------------------------------------------
  // Frame log and status register
  // ----------------------------------------------------------------
  logic [7:0] log_q[$];
  int len_q[$];
  int start_q[$];
  logic [7:0] status_r = 8'h9C; // Protected at power-up, so boot must clear it.
  logic [7:0] sr = 8'h00;
  logic [7:0] out_sr = 8'h00;
  logic [7:0] op = 8'h00;
  logic [23:0] addr = 24'h000000;
  int bits = 0;
  int nb = 0;
  int latch_wait = 0;
  int busy_wait = 0;
  int mode_err = 0;
  initial miso = 1'b0;

  // A select edge with the clock high is not mode 0.
  always @(negedge cs_n) begin
    if (sclk) mode_err++;
    bits = 0;
    nb = 0;
    start_q.push_back(log_q.size());
  end

  // Bits are taken on the rising clock edge, MSB first.
  always @(posedge sclk) begin
    if (!cs_n) begin
      sr = {sr[6:0], mosi};
      bits++;
      if (bits % 8 == 0) begin
        log_q.push_back(sr);
        nb++;
        if (nb == 1) op = sr;
        if (nb >= 2 && nb <= 4) addr = {addr[15:0], sr};
        if (op == 8'h05 && nb == 1) out_sr = status_r;
        if (op == 8'h0B && nb >= 5) out_sr = 8'(addr + 24'(nb - 5)); // Address auto-increments.
      end
    end
  end

  // Data leaves on the falling edge; an idle line toggles so stale bits cannot pass.
  always @(negedge sclk) begin
    if (!cs_n && ((op == 8'h05 && nb == 1) || (op == 8'h0B && nb >= 5))) begin
      miso = out_sr[7];
      out_sr = {out_sr[6:0], 1'b0};
    end else begin
      miso = ~miso;
    end
  end

  // End of frame: the command acts on the status register, slowly on purpose.
  always @(posedge cs_n) begin
    miso = ~miso;
    if (start_q.size() > len_q.size()) len_q.push_back(nb);
    if (op == 8'h06 && nb == 1) begin
      latch_wait = LATCH_POLLS;
      status_r[1] = (LATCH_POLLS == 0);
    end
    if (op == 8'h05 && nb == 2) begin
      if (latch_wait == 1) status_r[1] = 1'b1;
      if (busy_wait == 1) status_r[0] = 1'b0;
      if (latch_wait > 0) latch_wait--;
      if (busy_wait > 0) busy_wait--;
    end
    if ((op == 8'h01 && nb == 2) || (op == 8'h02 && nb >= 4) || (op == 8'h20 && nb == 4)
        || (op == 8'hC7 && nb == 1)) begin
      if (op == 8'h01) status_r[7:2] = log_q[log_q.size() - 1][7:2];
      status_r[1] = 1'b0; // The latch clears after any write.
      status_r[0] = (BUSY_POLLS != 0);
      busy_wait = BUSY_POLLS;
    end
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the serial flash command sequencer.
// Assumes the flash model's frame log and a pulled-up select line.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfc_pkg::*;
  localparam int LATCH_POLLS = 2;
  localparam int BUSY_POLLS = 3;
  typedef struct {
    sfc_cmd_t op;
    logic [23:0] addr;
    int len;
    logic [7:0] st;
    logic [7:0] opc;
    int flen;
    bit wr;
  } sfc_row_t;
  // ----------------------------------------------------------------
  // Signals, pull levels and instances
  // ----------------------------------------------------------------
  logic clk, arst_n, reset_in_n, fw_valid, cmd_valid, wr_valid, cmd_ready, wr_ready;
  logic rd_valid, busy, done, sclk, sclk_oe, mosi, mosi_oe, cs0_n, cs0_oe, cs1_n, miso;
  sfc_cmd_t cmd_op;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_len;
  logic [7:0] cmd_status, wr_data, rd_data, status;
  logic [7:0] rd_buf[16];
  int mismatches = 0;
  int tests_run = 0;
  int nrd;
  bit cs1_low = 0;
  // Released lines fall to board pulls: clock down, select and data up.
  wire logic sclk_w = sclk_oe ? sclk : 1'b0;
  wire logic cs_w = cs0_oe ? cs0_n : 1'b1;
  wire logic mosi_w = mosi_oe ? mosi : 1'b1;
  sfc_seq dut (.clk(clk), .arst_n(arst_n), .reset_in_n(reset_in_n), .fw_valid(fw_valid),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_status(cmd_status), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .status(status), .busy(busy),
    .done(done), .flash_sclk(sclk), .flash_sclk_oe(sclk_oe), .flash_mosi(mosi),
    .flash_mosi_oe(mosi_oe), .flash_cs0_n(cs0_n), .flash_cs0_oe(cs0_oe), .flash_cs1_n(cs1_n),
    .flash_miso(miso));
  sfc_flash_model #(.LATCH_POLLS(LATCH_POLLS), .BUSY_POLLS(BUSY_POLLS)) fm (.sclk(sclk_w),
    .cs_n(cs_w), .mosi(mosi_w), .miso(miso));
  // Ordinary commands, back to back: opcode and full frame length expected.
  sfc_row_t rows[8] = '{
    '{CMD_WRITE_ENABLE, 24'h000000, 0, 8'h00, 8'h06, 1, 0},
    '{CMD_FAST_READ, 24'h1234FE, 4, 8'h00, 8'h0B, 9, 0},
    '{CMD_WRITE_STATUS, 24'h000000, 0, 8'h3C, 8'h01, 2, 1},
    '{CMD_READ_STATUS, 24'h000000, 0, 8'h3C, 8'h05, 2, 0},
    '{CMD_PAGE_PROGRAM, 24'hABCDEF, 3, 8'h00, 8'h02, 7, 1},
    '{CMD_PAGE_PROGRAM, 24'h000100, 0, 8'h00, 8'h02, 4, 1},
    '{CMD_SECTOR_ERASE, 24'h00F000, 0, 8'h00, 8'h20, 4, 1},
    '{CMD_CHIP_ERASE, 24'h000000, 0, 8'h00, 8'hC7, 1, 1}
  };

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Held until busy shows that a rising edge took it; a ready that rises in the
  // same step as the firmware gate can then never lead to a second take.
  task automatic issue(input sfc_row_t r);
    int n;
    n = 0;
    cmd_op = r.op;
    cmd_addr = r.addr;
    cmd_len = 16'(r.len);
    cmd_status = r.st;
    cmd_valid = 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b1 && n < 2000);
    cmd_valid = 1'b0;
    if (n >= 2000) chk("command taken", 1, 0);
  endtask

  // Feeds program bytes, gathers read bytes, and waits a bounded time for done.
  task automatic wait_done(input int nwr, output int nr);
    int n, idx;
    bit take;
    n = 0;
    idx = 0;
    take = 0;
    nr = 0;
    do begin
      @(negedge clk);
      if (wr_valid && take) idx++;
      wr_valid = (idx < nwr);
      wr_data = 8'h5A + 8'(idx);
      take = wr_ready;
      if (rd_valid === 1'b1 && nr < 16) rd_buf[nr++] = rd_data;
      n++;
    end while (done !== 1'b1 && n < 20000);
    wr_valid = 1'b0;
    if (n >= 20000) chk("done", 1, 0);
  endtask

  task automatic chk_frm(inout int k, input logic [7:0] opc, input int len);
    chk("frame opcode", opc, fm.log_q[fm.start_q[k]]);
    chk("frame length", len, fm.len_q[k]);
    k++;
  endtask

  task automatic chk_write(inout int k, input logic [7:0] opc, input int len);
    chk_frm(k, OP_WRITE_ENABLE, 1);
    repeat (LATCH_POLLS + 1) chk_frm(k, OP_READ_STATUS, 2);
    chk_frm(k, opc, len);
    repeat (BUSY_POLLS + 1) chk_frm(k, OP_READ_STATUS, 2);
  endtask

  task automatic boot_check();
    int k;
    k = 0;
    chk_write(k, OP_WRITE_STATUS, 2);
    chk("boot status byte", 0, fm.log_q[fm.start_q[LATCH_POLLS + 2] + 1]);
    chk("boot frames", k, fm.len_q.size());
  endtask

  task automatic run_row(input sfc_row_t r);
    int k, ci, s;
    k = fm.len_q.size();
    ci = r.wr ? k + LATCH_POLLS + 2 : k;
    issue(r);
    wait_done(r.op == CMD_PAGE_PROGRAM ? r.len : 0, nrd);
    if (r.wr) chk_write(k, r.opc, r.flen);
    else chk_frm(k, r.opc, r.flen);
    chk("frame count", k, fm.len_q.size());
    s = fm.start_q[ci];
    if (r.op inside {CMD_FAST_READ, CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE}) begin
      for (int j = 0; j < 3; j++) begin
        chk("address byte", r.addr[23 - 8 * j -: 8], fm.log_q[s + 1 + j]);
      end
    end
    if (r.op == CMD_WRITE_STATUS) chk("status byte", r.st, fm.log_q[s + 1]);
    if (r.op == CMD_READ_STATUS) chk("status port", r.st, status);
    for (int j = 0; j < r.len; j++) begin
      if (r.op == CMD_PAGE_PROGRAM) chk("program byte", 8'h5A + j, fm.log_q[s + 4 + j]);
      if (r.op == CMD_FAST_READ) chk("read byte", 8'(r.addr[7:0] + j), rd_buf[j]);
    end
    if (r.op == CMD_FAST_READ) chk("read count", r.len, nrd);
    $display("test %s done", r.op.name());
  endtask

  // ----------------------------------------------------------------
  // Monitors, watchdog and main sequence
  // ----------------------------------------------------------------
  always @(negedge clk) if (cs1_n !== 1'b1) cs1_low = 1'b1;

  initial begin
    #400000;
    mismatches++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    arst_n = 1'b0;
    reset_in_n = 1'b1;
    fw_valid = 1'b1;
    cmd_valid = 1'b0;
    wr_valid = 1'b0;
    cmd_op = CMD_WRITE_ENABLE;
    cmd_addr = 24'h000000;
    cmd_len = 16'h0000;
    cmd_status = 8'h00;
    wr_data = 8'h00;
    repeat (12) @(negedge clk);
    chk("ready in reset", 0, cmd_ready);
    arst_n = 1'b1;
    wait_done(0, nrd);
    boot_check();
    $display("test boot done");
    foreach (rows[i]) run_row(rows[i]);
    // The firmware gate holds a waiting command off until it opens.
    fw_valid = 1'b0;
    fork
      begin
        repeat (10) @(negedge clk);
        chk("ready while gated", 0, cmd_ready);
        chk("busy while gated", 0, busy);
        fw_valid = 1'b1;
      end
      run_row(rows[0]);
    join
    // Reset pin in mid-command releases the pins, then boot runs again.
    issue(rows[7]);
    repeat (20) @(negedge clk);
    reset_in_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("pin enables", 0, {sclk_oe, mosi_oe, cs0_oe});
    chk("second select", 1, cs1_n);
    chk("ready in pin reset", 0, cmd_ready);
    fm.log_q.delete();
    fm.len_q.delete();
    fm.start_q.delete();
    reset_in_n = 1'b1;
    wait_done(0, nrd);
    boot_check();
    $display("test pin reset done");
    chk("mode 0 select edges", 0, fm.mode_err);
    chk("second select held", 0, cs1_low);
    end_of_test();
  end
endmodule
`default_nettype wire
